// file: core/parf_consts.svh
// Constants for the PCI port aperture remap filter
`ifndef PARF_CONSTS_SVH
`define PARF_CONSTS_SVH

`define PARF_ADDR_W        32
`define PARF_PAGE_SHIFT    12
`define PARF_TABLE_DEPTH   16
`define PARF_TABLE_IDX_W   4
`define PARF_APER_BASE_RST 32'he000_0000
`define PARF_APER_SIZE_RST 32'h0001_0000

`endif

// file: core/parf_pkg.sv
// Types for the PCI port aperture remap filter
package parf_pkg;
  typedef logic [31:0] parf_addr_t;
  typedef logic [3:0]  parf_idx_t;
  typedef enum logic [1:0] {PARF_PASS, PARF_REMAP, PARF_REJECT} parf_verdict_e;
endpackage

// file: core/parf_remap_table.sv
// Aperture remap table: page translation storage and lookup
`timescale 1ns/1ps
`include "parf_consts.svh"
module parf_remap_table
#(
  parameter int DEPTH = `PARF_TABLE_DEPTH,
  parameter int IDX_W = `PARF_TABLE_IDX_W,
  parameter int PFN_W = `PARF_ADDR_W - `PARF_PAGE_SHIFT
)
(
  input  wire logic             i_ref_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_wr_en,
  input  wire logic [IDX_W-1:0] i_wr_idx,
  input  wire logic [PFN_W-1:0] i_wr_pfn,
  input  wire logic [IDX_W-1:0] i_rd_idx,
  output logic      [PFN_W-1:0] o_rd_pfn
);
  import parf_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][PFN_W-1:0] entry;
  } parf_tbl_s;

  parf_tbl_s st;
  parf_tbl_s next_st;

  // ----------------------------------------
  // Table update
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    if (i_wr_en)
    begin
      next_st.entry[i_wr_idx] = i_wr_pfn;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  // Combinational lookup
  assign o_rd_pfn = st.entry[i_rd_idx];
endmodule

// file: core/parf_filter.sv
// PCI port aperture remap filter: classify, remap or reject PCI memory requests
`timescale 1ns/1ps
`include "parf_consts.svh"
module parf_filter
#(
  parameter int ADDR_W  = `PARF_ADDR_W,
  parameter int PG_SH   = `PARF_PAGE_SHIFT,
  parameter int IDX_W   = `PARF_TABLE_IDX_W,
  parameter int DEPTH   = `PARF_TABLE_DEPTH
)
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_cpu_remap_en,
  input  wire parf_pkg::parf_addr_t i_aper_base,
  input  wire parf_pkg::parf_addr_t i_aper_size,
  input  wire logic              i_tbl_wr_en,
  input  wire logic [IDX_W-1:0]  i_tbl_wr_idx,
  input  wire logic [ADDR_W-PG_SH-1:0] i_tbl_wr_pfn,
  input  wire logic              i_req_valid,
  input  wire parf_pkg::parf_addr_t i_req_addr,
  output logic                   o_fwd_valid,
  output parf_pkg::parf_addr_t   o_fwd_addr,
  output logic                   o_remapped,
  output logic                   o_access_err
);
  import parf_pkg::*;

  localparam int PFN_W = ADDR_W - PG_SH;

  typedef struct packed {
    logic       fwd_valid;
    parf_addr_t fwd_addr;
    logic       remapped;
    logic       access_err;
  } parf_state_s;

  parf_state_s st;
  parf_state_s next_st;

  logic [PFN_W-1:0] rd_pfn;
  logic [IDX_W-1:0] rd_idx;
  parf_addr_t       offset;
  logic             in_aper;
  parf_verdict_e    verdict;

  // ----------------------------------------
  // Aperture decode
  // ----------------------------------------
  // Base compare guards the low end, offset compare the high end
  assign offset  = i_req_addr - i_aper_base;
  assign in_aper = (i_req_addr >= i_aper_base) && (offset < i_aper_size);
  assign rd_idx  = offset[PG_SH +: IDX_W];

  parf_remap_table
  #(
    .DEPTH (DEPTH),
    .IDX_W (IDX_W),
    .PFN_W (PFN_W)
  )
  u_table
  (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_wr_en   (i_tbl_wr_en),
    .i_wr_idx  (i_tbl_wr_idx),
    .i_wr_pfn  (i_tbl_wr_pfn),
    .i_rd_idx  (rd_idx),
    .o_rd_pfn  (rd_pfn)
  );

  // Verdict per request
  always_comb
  begin
    if (!in_aper)
      verdict = PARF_PASS;
    else if (i_cpu_remap_en)
      verdict = PARF_REMAP;
    else
      verdict = PARF_REJECT;
  end

  // ----------------------------------------
  // Output register
  // ----------------------------------------
  always_comb
  begin
    next_st            = st;
    next_st.fwd_valid  = 1'b0;
    next_st.remapped   = 1'b0;
    next_st.access_err = 1'b0;
    if (i_req_valid)
    begin
      case (verdict)
        PARF_PASS:
        begin
          next_st.fwd_valid = 1'b1;
          next_st.fwd_addr  = i_req_addr;
        end
        PARF_REMAP:
        begin
          next_st.fwd_valid = 1'b1;
          next_st.remapped  = 1'b1;
          next_st.fwd_addr  = {rd_pfn, i_req_addr[PG_SH-1:0]};
        end
        PARF_REJECT:
        begin
          next_st.access_err = 1'b1;
        end
        default:
        begin
          next_st.access_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_fwd_valid  = st.fwd_valid;
  assign o_fwd_addr   = st.fwd_addr;
  assign o_remapped   = st.remapped;
  assign o_access_err = st.access_err;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_aper_req_off;
    i_req_valid && in_aper && !i_cpu_remap_en;
  endsequence

  property p_reject_no_fwd;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    s_aper_req_off |=> (!o_fwd_valid && o_access_err);
  endproperty
  a_reject_no_fwd: assert property (p_reject_no_fwd) else $error("aperture request forwarded with remap off");

  property p_err_flag;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    s_aper_req_off |=> o_access_err;
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("aperture access error not flagged");

  property p_remap_addr;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (i_req_valid && in_aper && i_cpu_remap_en) |=>
      (o_fwd_valid && o_remapped && o_fwd_addr == {$past(rd_pfn), $past(i_req_addr[PG_SH-1:0])});
  endproperty
  a_remap_addr: assert property (p_remap_addr) else $error("aperture address not remapped");

  property p_pass_unchanged;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (i_req_valid && !in_aper) |=> (o_fwd_valid && !o_remapped && o_fwd_addr == $past(i_req_addr));
  endproperty
  a_pass_unchanged: assert property (p_pass_unchanged) else $error("outside address altered");

  property p_no_remap_off;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (i_req_valid && !i_cpu_remap_en) |=> !o_remapped;
  endproperty
  a_no_remap_off: assert property (p_no_remap_off) else $error("remap done while disabled");

  property p_no_raw_aper;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (i_req_valid && in_aper) |=> (!o_fwd_valid || o_remapped);
  endproperty
  a_no_raw_aper: assert property (p_no_raw_aper) else $error("raw aperture address forwarded");

  property p_err_excl;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    o_access_err |-> !o_fwd_valid;
  endproperty
  a_err_excl: assert property (p_err_excl) else $error("error and forward together");

  property p_idle_quiet;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    !i_req_valid |=> (!o_fwd_valid && !o_access_err);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output without request");

  sequence s_aper_req_on;
    i_req_valid && in_aper && i_cpu_remap_en;
  endsequence

  sequence s_any_req;
    i_req_valid;
  endsequence

  // Rejected request leaves the forward address untouched
  property p_reject_addr_hold;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    s_aper_req_off |=> $stable(o_fwd_addr);
  endproperty
  a_reject_addr_hold: assert property (p_reject_addr_hold) else $error("rejected address reached forward port");

  // Every request ends in exactly one outcome one cycle later
  property p_one_outcome;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    s_any_req |=> (o_fwd_valid != o_access_err);
  endproperty
  a_one_outcome: assert property (p_one_outcome) else $error("request without single outcome");

  // Remap flag only rides on a forward
  property p_remap_fwd;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    o_remapped |-> o_fwd_valid;
  endproperty
  a_remap_fwd: assert property (p_remap_fwd) else $error("remap flag without forward");

  // Aperture hit with remap on never ends as an error
  property p_remap_path;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    s_aper_req_on |=> (o_remapped && !o_access_err);
  endproperty
  a_remap_path: assert property (p_remap_path) else $error("remap path not taken");
endmodule

// file: verif/parf_pci_master.sv
// PCI bus master model issuing memory requests
`timescale 1ns/1ps
module parf_pci_master
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_arst_n,
  input  wire logic                 i_go,
  input  wire parf_pkg::parf_addr_t i_go_addr,
  input  wire logic                 i_fwd_valid,
  output logic                      o_req_valid,
  output parf_pkg::parf_addr_t      o_req_addr,
  output logic                      o_abort
);
  import parf_pkg::*;
  logic pend;
  // One request per go; idle address lines wander
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_req_valid <= 1'b0;
      o_req_addr  <= 32'h0;
      pend        <= 1'b0;
      o_abort     <= 1'b0;
    end
    else
    begin
      o_req_valid <= i_go;
      o_req_addr  <= i_go ? i_go_addr : ~o_req_addr;
      pend        <= o_req_valid;
      o_abort     <= pend & ~i_fwd_valid;
    end
  end
endmodule

// file: verif/pci_port_aperture_remap_filter_tb.sv
// Self-checking bench for the PCI port aperture remap filter
`timescale 1ns/1ps
`include "parf_consts.svh"
module pci_port_aperture_remap_filter_tb;
  import parf_pkg::*;
  localparam parf_addr_t B = `PARF_APER_BASE_RST;
  localparam parf_addr_t S = `PARF_APER_SIZE_RST;
  parf_addr_t  aper_base = `PARF_APER_BASE_RST;
  parf_addr_t  aper_size = `PARF_APER_SIZE_RST;
  logic        clk      = 1'b0;
  logic        arst_n   = 1'b0;
  logic        remap_en = 1'b1;
  logic        wr_en    = 1'b0;
  logic [3:0]  wr_idx   = 4'h0;
  logic [19:0] wr_pfn   = 20'h0;
  logic        go       = 1'b0;
  parf_addr_t  go_addr  = 32'h0;
  logic        req_valid, fwd_valid, remapped, access_err, abort;
  parf_addr_t  req_addr, fwd_addr;
  int          errors = 0, compares = 0, cyc = 0;

  always #25 clk = ~clk;

  parf_pci_master pm (.i_ref_clk(clk), .i_arst_n(arst_n), .i_go(go), .i_go_addr(go_addr),
    .i_fwd_valid(fwd_valid), .o_req_valid(req_valid), .o_req_addr(req_addr), .o_abort(abort));

  parf_filter uut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_cpu_remap_en(remap_en), .i_aper_base(aper_base),
    .i_aper_size(aper_size), .i_tbl_wr_en(wr_en), .i_tbl_wr_idx(wr_idx), .i_tbl_wr_pfn(wr_pfn),
    .i_req_valid(req_valid), .i_req_addr(req_addr), .o_fwd_valid(fwd_valid),
    .o_fwd_addr(fwd_addr), .o_remapped(remapped), .o_access_err(access_err));

  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // Write one remap table entry
  task automatic wr(input logic [3:0] i, input logic [19:0] p);
    @(posedge clk);
    wr_en  <= 1'b1;
    wr_idx <= i;
    wr_pfn <= p;
    @(posedge clk);
    wr_en  <= 1'b0;
  endtask

  // One request through the master; judge answer and termination
  task automatic send(input parf_addr_t a, input logic f, input parf_addr_t x, input logic r);
    @(posedge clk);
    go      <= 1'b1;
    go_addr <= a;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    chk(fwd_valid === f && access_err === !f && remapped === r && (!f || fwd_addr === x), "answer");
    @(posedge clk);
    #1;
    chk(abort === !f && fwd_valid === 1'b0 && access_err === 1'b0, "termination");
  endtask

  task automatic t_remap;
    @(posedge clk);
    remap_en <= 1'b1;
    wr(4'h3, 20'habcde);
    send(B + 32'h3123, 1'b1, {20'habcde, 12'h123}, 1'b1);
    send(B + 32'h0456, 1'b1, 32'h0000_0456, 1'b1);
  endtask

  task automatic t_outside;
    send(B - 32'h1, 1'b1, B - 32'h1, 1'b0);
    send(B + S, 1'b1, B + S, 1'b0);
  endtask

  task automatic t_noremap;
    @(posedge clk);
    remap_en <= 1'b0;
    send(B + 32'h3123, 1'b0, 32'h0, 1'b0);
    send(B + S - 32'h1, 1'b0, 32'h0, 1'b0);
    send(B + S, 1'b1, B + S, 1'b0);
  endtask

  // Aperture moved and shrunk: decode follows the new window
  task automatic t_move;
    @(posedge clk);
    remap_en  <= 1'b1;
    aper_base <= 32'h4000_0000;
    aper_size <= 32'h0000_2000;
    wr(4'h1, 20'h12345);
    send(32'h4000_1abc, 1'b1, {20'h12345, 12'habc}, 1'b1);
    send(32'h4000_2000, 1'b1, 32'h4000_2000, 1'b0);
    send(B + 32'h3123, 1'b1, B + 32'h3123, 1'b0);
  endtask

  // Reset in mid-run: outputs drop, table clears, request right after release
  task automatic t_reset_mid;
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk(fwd_valid === 1'b0 && access_err === 1'b0 && remapped === 1'b0 && abort === 1'b0 && fwd_addr === 32'h0,
      "mid reset");
    @(posedge clk);
    arst_n <= 1'b1;
    send(32'h4000_1abc, 1'b1, 32'h0000_0abc, 1'b1);
  endtask

  // Cycle ceiling against hangs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errors++;
      stop_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk(fwd_valid === 1'b0 && access_err === 1'b0 && remapped === 1'b0 && fwd_addr === 32'h0, "reset");
    t_remap();
    t_outside();
    t_noremap();
    t_move();
    t_reset_mid();
    stop_test();
  end
endmodule
